// File: rtl/cdsx_pkg.sv
package cdsx_pkg;
  // opcode fields of the 14-bit instruction word
  localparam int INSTR_W = 14;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam int OPC_MSB = 13;
  localparam int OPC_LSB = 8;
  localparam int DEST_BIT = 7;
  localparam logic [5:0] OPC_COMPLEMENT = 6'h09;
  localparam logic [5:0] OPC_DECSKIP = 6'h0B;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [7:0] ONE_BYTE = 8'h01;
  localparam logic [6:0] ADDR_RESET = 7'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;

  typedef enum logic [1:0] {
    CDSX_OP_NONE,
    CDSX_OP_COMPLEMENT,
    CDSX_OP_DECSKIP
  } cdsx_op_type;
endpackage

// File: rtl/cdsx_decode.sv
// combinational opcode decode of one instruction word
module cdsx_decode (
  input wire logic [13:0] instr,
  output cdsx_pkg::cdsx_op_type op,
  output logic dest_reg,
  output logic [6:0] addr
);
  // opcode match on bits 13:8
  always_comb begin
    unique case (instr[cdsx_pkg::OPC_MSB:cdsx_pkg::OPC_LSB])
      cdsx_pkg::OPC_COMPLEMENT: op = cdsx_pkg::CDSX_OP_COMPLEMENT;
      cdsx_pkg::OPC_DECSKIP: op = cdsx_pkg::CDSX_OP_DECSKIP;
      default: op = cdsx_pkg::CDSX_OP_NONE;
    endcase
  end

  // operand fields
  assign dest_reg = instr[cdsx_pkg::DEST_BIT];
  assign addr = instr[cdsx_pkg::ADDR_W-1:0];
endmodule

// File: rtl/cdsx_exec.sv
module cdsx_exec (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic instr_valid,
  input wire logic [13:0] instr,
  input wire logic [7:0] reg_rdata,
  output logic [6:0] reg_addr_q,
  output logic [7:0] reg_wdata_q,
  output logic reg_we_q,
  output logic [7:0] acc_wdata_q,
  output logic acc_we_q,
  output logic zero_flag_q,
  output logic zero_we_q,
  output logic no_operation_cycle_q,
  output logic busy_q
);
  cdsx_pkg::cdsx_op_type op;
  logic dest_reg;
  logic [6:0] addr;
  logic [7:0] result_d;
  logic [7:0] complement_register_op;
  logic [7:0] decrement_skip_zero_op;
  logic exec_ok;
  logic skip_d;
  logic skip_q;

  cdsx_decode u_decode (
    .instr(instr),
    .op(op),
    .dest_reg(dest_reg),
    .addr(addr)
  );

  // the word after a skipping decrement is squashed, not executed
  assign exec_ok = ce && instr_valid && !skip_q;

  // the two arithmetic results
  assign complement_register_op = ~reg_rdata;
  assign decrement_skip_zero_op = reg_rdata - cdsx_pkg::ONE_BYTE;

  // result select and skip decision
  always_comb begin
    result_d = cdsx_pkg::DATA_RESET;
    skip_d = 1'b0;
    unique case (op)
      cdsx_pkg::CDSX_OP_COMPLEMENT: begin
        result_d = complement_register_op;
      end
      cdsx_pkg::CDSX_OP_DECSKIP: begin
        result_d = decrement_skip_zero_op;
        skip_d = decrement_skip_zero_op == cdsx_pkg::ZERO_BYTE;
      end
      cdsx_pkg::CDSX_OP_NONE: begin
        result_d = cdsx_pkg::DATA_RESET;
      end
    endcase
  end

  // register address follows decoded operand
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_addr_q <= cdsx_pkg::ADDR_RESET;
    end else if (exec_ok) begin
      reg_addr_q <= addr;
    end
  end

  // destination routing for both operations
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_wdata_q <= cdsx_pkg::DATA_RESET;
      reg_we_q <= 1'b0;
      acc_wdata_q <= cdsx_pkg::DATA_RESET;
      acc_we_q <= 1'b0;
    end else if (ce) begin
      reg_we_q <= exec_ok && op != cdsx_pkg::CDSX_OP_NONE && dest_reg;
      acc_we_q <= exec_ok && op != cdsx_pkg::CDSX_OP_NONE && !dest_reg;
      if (exec_ok && dest_reg) begin
        reg_wdata_q <= result_d;
      end
      if (exec_ok && !dest_reg) begin
        acc_wdata_q <= result_d;
      end
    end
  end

  // zero flag only from the complement, never from decrement
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      zero_flag_q <= 1'b0;
      zero_we_q <= 1'b0;
    end else if (ce) begin
      zero_we_q <= exec_ok && op == cdsx_pkg::CDSX_OP_COMPLEMENT;
      if (exec_ok && op == cdsx_pkg::CDSX_OP_COMPLEMENT) begin
        zero_flag_q <= complement_register_op == cdsx_pkg::ZERO_BYTE;
      end
    end
  end

  // skip pending covers exactly the next instruction slot
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      skip_q <= 1'b0;
      no_operation_cycle_q <= 1'b0;
      busy_q <= 1'b0;
    end else if (ce) begin
      skip_q <= exec_ok && skip_d;
      no_operation_cycle_q <= skip_q;
      busy_q <= exec_ok && skip_d;
    end
  end

  // assertions
  sequence s_skip_issue;
    ce && instr_valid && !skip_q && op == cdsx_pkg::CDSX_OP_DECSKIP
      && reg_rdata == cdsx_pkg::ONE_BYTE;
  endsequence

  sequence s_nop_slot;
    !reg_we_q && !acc_we_q && no_operation_cycle_q;
  endsequence

  a_comp_result: assert property (@(posedge clk) disable iff (rst)
    ce && exec_ok && op == cdsx_pkg::CDSX_OP_COMPLEMENT && !dest_reg
    |=> acc_we_q && acc_wdata_q == ~$past(reg_rdata))
    else $error("complement result wrong");

  a_comp_dest: assert property (@(posedge clk) disable iff (rst)
    ce && exec_ok && op == cdsx_pkg::CDSX_OP_COMPLEMENT && dest_reg
    |=> reg_we_q && !acc_we_q && reg_addr_q == $past(instr[6:0]))
    else $error("complement destination wrong");

  a_comp_zero: assert property (@(posedge clk) disable iff (rst)
    ce && exec_ok && op == cdsx_pkg::CDSX_OP_COMPLEMENT
    |=> zero_we_q && zero_flag_q == ($past(reg_rdata) == 8'hFF))
    else $error("zero flag wrong");

  a_dec_noflag: assert property (@(posedge clk) disable iff (rst)
    ce && exec_ok && op == cdsx_pkg::CDSX_OP_DECSKIP
    |=> !zero_we_q && $stable(zero_flag_q))
    else $error("decrement touched flag");

  a_dec_dest: assert property (@(posedge clk) disable iff (rst)
    ce && exec_ok && op == cdsx_pkg::CDSX_OP_DECSKIP && dest_reg
    |=> reg_we_q && reg_wdata_q == $past(reg_rdata) - 8'h01)
    else $error("decrement destination wrong");

  a_skip_squash: assert property (@(posedge clk) disable iff (rst)
    s_skip_issue ##1 ce |=> !reg_we_q && !acc_we_q && !zero_we_q)
    else $error("skipped instruction took effect");

  a_skip_nop: assert property (@(posedge clk) disable iff (rst)
    s_skip_issue ##1 ce |=> s_nop_slot)
    else $error("no nop slot after skip");

  a_skip_busy: assert property (@(posedge clk) disable iff (rst)
    s_skip_issue |=> busy_q && skip_q)
    else $error("skip not raised");

  a_skip_once: assert property (@(posedge clk) disable iff (rst)
    s_skip_issue ##1 ce ##1 ce |=> !no_operation_cycle_q)
    else $error("nop slot longer than one cycle");

  a_dec_wrap: assert property (@(posedge clk) disable iff (rst)
    exec_ok && op == cdsx_pkg::CDSX_OP_DECSKIP
      && reg_rdata == cdsx_pkg::ZERO_BYTE |=> !busy_q)
    else $error("wrapping decrement skipped");

  a_comp_acc: assert property (@(posedge clk) disable iff (rst)
    exec_ok && op == cdsx_pkg::CDSX_OP_COMPLEMENT && !dest_reg
    |=> acc_we_q && !reg_we_q)
    else $error("complement wrote register");

  a_dec_acc: assert property (@(posedge clk) disable iff (rst)
    exec_ok && op == cdsx_pkg::CDSX_OP_DECSKIP && !dest_reg
    |=> acc_we_q && !reg_we_q
      && acc_wdata_q == $past(reg_rdata) - 8'h01)
    else $error("decrement accumulator wrong");

  a_dec_addr: assert property (@(posedge clk) disable iff (rst)
    exec_ok && op == cdsx_pkg::CDSX_OP_DECSKIP && dest_reg
    |=> reg_addr_q == $past(instr[6:0]))
    else $error("decrement address wrong");

  a_foreign_quiet: assert property (@(posedge clk) disable iff (rst)
    ce && (op == cdsx_pkg::CDSX_OP_NONE || !instr_valid)
    |=> !reg_we_q && !acc_we_q && !zero_we_q)
    else $error("foreign word gave a strobe");

  a_ce_freeze: assert property (@(posedge clk) disable iff (rst)
    !ce |=> $stable(acc_wdata_q) && $stable(reg_wdata_q)
      && $stable(zero_flag_q) && $stable(reg_addr_q))
    else $error("state moved while frozen");

  a_no_skip: assert property (@(posedge clk) disable iff (rst)
    ce && exec_ok && op == cdsx_pkg::CDSX_OP_DECSKIP
      && reg_rdata != cdsx_pkg::ONE_BYTE |=> !skip_q && !busy_q)
    else $error("spurious skip");
endmodule

// File: dv/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic instr_valid = 1'b0;
  logic [13:0] instr = 14'h0000;
  logic [7:0] reg_rdata = 8'h00;
  logic [6:0] reg_addr_q;
  logic [7:0] reg_wdata_q;
  logic reg_we_q;
  logic [7:0] acc_wdata_q;
  logic acc_we_q;
  logic zero_flag_q;
  logic zero_we_q;
  logic no_operation_cycle_q;
  logic busy_q;
  logic [7:0] strobes;
  int n_fail = 0;
  int num_checks = 0;
  int cyc = 0;

  cdsx_exec u_cdsx_exec (.clk(clk), .rst(rst), .ce(ce),
    .instr_valid(instr_valid), .instr(instr), .reg_rdata(reg_rdata),
    .reg_addr_q(reg_addr_q), .reg_wdata_q(reg_wdata_q),
    .reg_we_q(reg_we_q), .acc_wdata_q(acc_wdata_q), .acc_we_q(acc_we_q),
    .zero_flag_q(zero_flag_q), .zero_we_q(zero_we_q),
    .no_operation_cycle_q(no_operation_cycle_q), .busy_q(busy_q));

  // strobes packed as reg, acc, zero, no-op
  assign strobes = {4'h0, reg_we_q, acc_we_q, zero_we_q,
    no_operation_cycle_q};

  // clock and hang guard
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      n_fail++;
      results();
    end
  end

  task results();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task step(input logic v, input logic [13:0] i, input logic [7:0] d);
    @(posedge clk);
    #1;
    instr_valid = v;
    instr = i;
    reg_rdata = d;
  endtask

  task chk(input string s, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s exp %h got %h", s, e, g);
    end
  endtask

  // complement into accumulator
  task t_comp_acc();
    step(1'b1, 14'h0913, 8'h13);
    step(1'b0, 14'h0000, 8'h00);
    chk("strobes", 8'h06, strobes);
    chk("acc", 8'hEC, acc_wdata_q);
    chk("zero", 8'h00, {7'h00, zero_flag_q});
  endtask

  // complement back into top register, result zero
  task t_comp_reg();
    step(1'b1, 14'h09FF, 8'hFF);
    step(1'b0, 14'h0000, 8'h00);
    chk("strobes", 8'h0A, strobes);
    chk("wdata", 8'h00, reg_wdata_q);
    chk("addr", 8'h7F, {1'b0, reg_addr_q});
    chk("zero", 8'h01, {7'h00, zero_flag_q});
  endtask

  // decrement wraps to ff, no skip, next word runs
  task t_dec_acc();
    step(1'b1, 14'h0B00, 8'h00);
    step(1'b1, 14'h0913, 8'h13);
    chk("strobes", 8'h04, strobes);
    chk("acc", 8'hFF, acc_wdata_q);
    step(1'b0, 14'h0000, 8'h00);
    chk("strobes", 8'h06, strobes);
  endtask

  // decrement to zero squashes the next word
  task t_dec_skip();
    step(1'b1, 14'h0B85, 8'h01);
    step(1'b1, 14'h0913, 8'h13);
    chk("strobes", 8'h08, strobes);
    chk("wdata", 8'h00, reg_wdata_q);
    chk("addr", 8'h05, {1'b0, reg_addr_q});
    chk("busy", 8'h01, {7'h00, busy_q});
    step(1'b0, 14'h0000, 8'h00);
    chk("strobes", 8'h01, strobes);
  endtask

  // foreign opcode and frozen enable give nothing
  task t_refused();
    step(1'b1, 14'h0A05, 8'h01);
    step(1'b0, 14'h0000, 8'h00);
    chk("strobes", 8'h00, strobes);
    ce = 1'b0;
    step(1'b1, 14'h0913, 8'h13);
    step(1'b0, 14'h0000, 8'h00);
    ce = 1'b1;
    chk("strobes", 8'h00, strobes);
  endtask

  // main sequence
  initial begin
    repeat (4) @(posedge clk);
    #1;
    rst = 1'b0;
    chk("reset", 8'h00, strobes);
    t_comp_acc();
    t_comp_reg();
    t_dec_acc();
    t_dec_skip();
    t_refused();
    results();
  end
endmodule
